// file: common/afac_defs.svh
`ifndef AFAC_DEFS_SVH
`define AFAC_DEFS_SVH

`define AFAC_CLK_MHZ 200
`define AFAC_CLK_PS 5000
`define AFAC_ROW_W 16
`define AFAC_COL_W 2
`define AFAC_ADDR_W 18
`define AFAC_DATA_W 16
`define AFAC_CNT_W 17

// times as printed
`define AFAC_TPU_US 450
`define AFAC_TROW_NS 110
`define AFAC_TWP_NS 16
`define AFAC_TASP_NS 8
`define AFAC_TAAP_NS 25
`define AFAC_TCOL_NS 10
`define AFAC_TPC_NS 55

// least times, rounded up to whole cycles
`define AFAC_NS2CYC(ns) (((ns) * 1000 + `AFAC_CLK_PS - 1) / `AFAC_CLK_PS)
`define AFAC_TPU_CYC (`AFAC_TPU_US * `AFAC_CLK_MHZ)
`define AFAC_ROW_CYC `AFAC_NS2CYC(`AFAC_TROW_NS)
`define AFAC_WP_CYC `AFAC_NS2CYC(`AFAC_TWP_NS)
`define AFAC_ASP_CYC `AFAC_NS2CYC(`AFAC_TASP_NS)
`define AFAC_PRD_CYC `AFAC_NS2CYC(`AFAC_TAAP_NS)
`define AFAC_COL_CYC `AFAC_NS2CYC(`AFAC_TCOL_NS)
`define AFAC_PC_CYC `AFAC_NS2CYC(`AFAC_TPC_NS)

`endif

// file: common/afac_pkg.sv
`include "afac_defs.svh"

package afac_pkg;

  typedef enum logic [6:0] {
    AFAC_PWRUP = 7'h01,
    AFAC_IDLE = 7'h02,
    AFAC_ACT = 7'h04,
    AFAC_WPULSE = 7'h08,
    AFAC_OPEN = 7'h10,
    AFAC_PSETUP = 7'h20,
    AFAC_PRE = 7'h40
  } afac_state_t;

  typedef struct packed {
    afac_state_t st;
    logic [`AFAC_CNT_W-1:0] cnt;
    logic wr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic ub_n;
    logic lb_n;
    logic [`AFAC_ADDR_W-1:0] addr;
    logic [`AFAC_DATA_W-1:0] dq;
    logic dq_oe;
    logic [`AFAC_DATA_W-1:0] rdata;
    logic rvalid;
    logic ack;
    logic ready;
  } afac_regs_t;

endpackage : afac_pkg

// file: logic/afac_ctrl.sv
`timescale 1ns/1ps
`include "afac_defs.svh"
module afac_ctrl
  import afac_pkg::*;
#(
  parameter int PU_CYCLES = `AFAC_TPU_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [`AFAC_ADDR_W-1:0] addr_in,
  input wire logic [`AFAC_DATA_W-1:0] wdata_in,
  input wire logic [1:0] be_in,
  input wire logic hold_page_in,
  input wire logic [`AFAC_DATA_W-1:0] dq_in,
  output logic ready_out,
  output logic ack_out,
  output logic [`AFAC_DATA_W-1:0] rdata_out,
  output logic rvalid_out,
  output logic chip_select_n_out,
  output logic write_strobe_n_out,
  output logic output_enable_n_out,
  output logic upper_byte_mask_n_out,
  output logic lower_byte_mask_n_out,
  output logic [`AFAC_ADDR_W-1:0] addr_out,
  output logic [`AFAC_DATA_W-1:0] dq_out,
  output logic dq_oe_out
);

  localparam int CW = `AFAC_CNT_W;
  localparam logic [CW-1:0] PU_LAST = CW'(PU_CYCLES - 1);
  localparam logic [CW-1:0] ROW_LAST = CW'(`AFAC_ROW_CYC - 1);
  localparam logic [CW-1:0] WP_LAST = CW'(`AFAC_WP_CYC - 1);
  localparam logic [CW-1:0] ASP_LAST = CW'(`AFAC_ASP_CYC - 1);
  localparam logic [CW-1:0] PRD_LAST = CW'(`AFAC_PRD_CYC - 1);
  localparam logic [CW-1:0] PC_LAST = CW'(`AFAC_PC_CYC - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  afac_regs_t q;
  afac_regs_t d;

  function automatic logic same_row(input logic [`AFAC_ADDR_W-1:0] a,
                                    input logic [`AFAC_ADDR_W-1:0] b);
    same_row = (a[`AFAC_ADDR_W-1:`AFAC_COL_W] == b[`AFAC_ADDR_W-1:`AFAC_COL_W]);
  endfunction : same_row

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.ack = 1'b0;
    d.cnt = q.cnt + CNT_ONE;
    case (q.st)
      AFAC_PWRUP: begin
        if (q.cnt == PU_LAST) begin
          d.st = AFAC_IDLE;
          d.ready = 1'b1;
        end
      end
      AFAC_IDLE: begin
        if (req_in) begin
          d.addr = addr_in;
          d.ub_n = ~be_in[1];
          d.lb_n = ~be_in[0];
          d.wr = wr_in;
          d.dq = wdata_in;
          d.dq_oe = wr_in;
          d.oe_n = wr_in;
          d.ce_n = 1'b0;
          d.ready = 1'b0;
          d.ack = 1'b1;
          d.cnt = '0;
          d.st = AFAC_ACT;
        end
      end
      AFAC_ACT: begin
        if (q.cnt == ROW_LAST) begin
          d.cnt = '0;
          if (q.wr) begin
            d.we_n = 1'b0;
            d.st = AFAC_WPULSE;
          end else begin
            d.rdata = dq_in;
            d.rvalid = 1'b1;
            d.ready = 1'b1;
            d.st = AFAC_OPEN;
          end
        end
      end
      AFAC_WPULSE: begin
        if (q.cnt == WP_LAST) begin
          d.we_n = 1'b1;
          d.ready = 1'b1;
          d.st = AFAC_OPEN;
        end
      end
      AFAC_OPEN: begin
        // data held one cycle past the strobe rise
        d.dq_oe = 1'b0;
        d.oe_n = 1'b0;
        d.cnt = '0;
        if (req_in && same_row(addr_in, q.addr)) begin
          d.addr = addr_in;
          d.ub_n = ~be_in[1];
          d.lb_n = ~be_in[0];
          d.wr = wr_in;
          d.dq = wdata_in;
          d.dq_oe = wr_in;
          d.oe_n = wr_in;
          d.ready = 1'b0;
          d.ack = 1'b1;
          d.st = AFAC_PSETUP;
        end else if (req_in || !hold_page_in) begin
          d.ce_n = 1'b1;
          d.oe_n = 1'b1;
          d.ready = 1'b0;
          d.st = AFAC_PRE;
        end
      end
      AFAC_PSETUP: begin
        if (q.wr && q.cnt == ASP_LAST) begin
          d.we_n = 1'b0;
          d.cnt = '0;
          d.st = AFAC_WPULSE;
        end else if (!q.wr && q.cnt == PRD_LAST) begin
          d.rdata = dq_in;
          d.rvalid = 1'b1;
          d.ready = 1'b1;
          d.st = AFAC_OPEN;
        end
      end
      AFAC_PRE: begin
        if (q.cnt == PC_LAST) begin
          d.ready = 1'b1;
          d.st = AFAC_IDLE;
        end
      end
      default: begin
        d.st = AFAC_PRE;
        d.ce_n = 1'b1;
        d.we_n = 1'b1;
        d.oe_n = 1'b1;
        d.dq_oe = 1'b0;
        d.ready = 1'b0;
        d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '{st: AFAC_PWRUP, cnt: '0, wr: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
             ub_n: 1'b1, lb_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0, rdata: '0,
             rvalid: 1'b0, ack: 1'b0, ready: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign ready_out = q.ready;
  assign ack_out = q.ack;
  assign rdata_out = q.rdata;
  assign rvalid_out = q.rvalid;
  assign chip_select_n_out = q.ce_n;
  assign write_strobe_n_out = q.we_n;
  assign output_enable_n_out = q.oe_n;
  assign upper_byte_mask_n_out = q.ub_n;
  assign lower_byte_mask_n_out = q.lb_n;
  assign addr_out = q.addr;
  assign dq_out = q.dq;
  assign dq_oe_out = q.dq_oe;

  // helper: cycles since reset, saturating
  logic [CW-1:0] since_rst_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      since_rst_q <= '0;
    end else if (since_rst_q != PU_LAST) begin
      since_rst_q <= since_rst_q + CNT_ONE;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_pu_wait;
    !chip_select_n_out |-> since_rst_q == PU_LAST;
  endproperty
  a_pu_wait: assert property (p_pu_wait) else $error("access before power-up wait");

  sequence s_sel_held;
    !chip_select_n_out && $past(!chip_select_n_out);
  endsequence
  property p_row_fixed;
    s_sel_held |-> $stable(addr_out[`AFAC_ADDR_W-1:`AFAC_COL_W]);
  endproperty
  a_row_fixed: assert property (p_row_fixed) else $error("row moved with select low");

  property p_col_hold;
    $changed(addr_out[`AFAC_COL_W-1:0]) |=> $stable(addr_out[`AFAC_COL_W-1:0]) [*4];
  endproperty
  a_col_hold: assert property (p_col_hold) else $error("column held too briefly");

  property p_mask_stable;
    !write_strobe_n_out && $past(!write_strobe_n_out)
      |-> $stable({upper_byte_mask_n_out, lower_byte_mask_n_out});
  endproperty
  a_mask_stable: assert property (p_mask_stable) else $error("mask moved in write");

  property p_sel_first;
    $fell(write_strobe_n_out) |-> s_sel_held;
  endproperty
  a_sel_first: assert property (p_sel_first) else $error("strobe fell before select");

  property p_data_at_rise;
    $fell(write_strobe_n_out) |-> (dq_oe_out && !write_strobe_n_out) [*4]
      ##1 (write_strobe_n_out && dq_oe_out);
  endproperty
  a_data_at_rise: assert property (p_data_at_rise) else $error("data not held to rise");

  property p_pre_len;
    $rose(chip_select_n_out) |-> chip_select_n_out [*8] ##1 chip_select_n_out [*3];
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("pre-charge cut short");

  property p_page_read;
    rvalid_out |-> !chip_select_n_out && !output_enable_n_out && write_strobe_n_out;
  endproperty
  a_page_read: assert property (p_page_read) else $error("read sampled outside access");

endmodule : afac_ctrl

// file: verification/afac_mem_model.sv
`timescale 1ns/1ps
module afac_mem_model (
  input wire logic sel_n_in,
  input wire logic strobe_n_in,
  input wire logic oe_n_in,
  input wire logic upper_byte_mask_n_in,
  input wire logic lower_byte_mask_n_in,
  input wire logic [17:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [0:262143];
  logic [15:0] last_q = 16'h0000;

  task automatic store();
    if (!upper_byte_mask_n_in) mem[addr_in][15:8] = dq_in[15:8];
    if (!lower_byte_mask_n_in) mem[addr_in][7:0] = dq_in[7:0];
  endtask : store

  always @(posedge strobe_n_in) if (!sel_n_in) store();
  always @(posedge sel_n_in) if (!strobe_n_in) store();

  // reads track address
  // released bus inverts, so a stale value never passes for a read
  always @* begin
    if (!sel_n_in && !oe_n_in && strobe_n_in) begin
      dq_out = mem[addr_in];
      last_q = dq_out;
    end else begin
      dq_out = ~last_q;
    end
  end
endmodule : afac_mem_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 0, resetn_in = 0, req_in = 0, wr_in = 0, hold_page_in = 0;
  logic [17:0] addr_in = 0, addr_out;
  logic [15:0] wdata_in = 0, dq_in, rdata_out, dq_out, mem_dq;
  logic [1:0] be_in = 0;
  logic ready_out, ack_out, rvalid_out, cs_n, we_n, oe_n, um_n, lm_n, dq_oe_out;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  logic [31:0] rng = 49;
  logic [15:0] ref_mem [0:262143];
  localparam int PU_TB = 20;

  always #2.5 clk_in = ~clk_in;
  assign dq_in = dq_oe_out ? dq_out : mem_dq;

  afac_ctrl #(.PU_CYCLES(PU_TB)) dut (.clk_in, .resetn_in, .req_in, .wr_in, .addr_in,
    .wdata_in, .be_in, .hold_page_in, .dq_in, .ready_out, .ack_out, .rdata_out,
    .rvalid_out, .chip_select_n_out(cs_n), .write_strobe_n_out(we_n),
    .output_enable_n_out(oe_n), .upper_byte_mask_n_out(um_n),
    .lower_byte_mask_n_out(lm_n), .addr_out, .dq_out, .dq_oe_out);
  afac_mem_model far (.sel_n_in(cs_n), .strobe_n_in(we_n), .oe_n_in(oe_n),
    .upper_byte_mask_n_in(um_n), .lower_byte_mask_n_in(lm_n), .addr_in(addr_out),
    .dq_in(dq_in), .dq_out(mem_dq));

  function automatic logic [15:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // request held until ack is seen at an edge; reads compared against the bench image
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
                    input logic [1:0] b, input logic h);
    int n;
    req_in <= 1'h1;
    wr_in <= w;
    addr_in <= a;
    wdata_in <= d;
    be_in <= b;
    hold_page_in <= h;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_out !== 1'h1 && n < 200);
    req_in <= 1'h0;
    if (ack_out !== 1'h1) begin
      fail_count++;
      $display("BAD t=%0t no ack", $time);
    end
    if (w) begin
      if (b[1]) ref_mem[a][15:8] = d[15:8];
      if (b[0]) ref_mem[a][7:0] = d[7:0];
      // an edge passes so the next call never re-raises req_in in this step
      @(posedge clk_in);
    end else begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (rvalid_out !== 1'h1 && n < 100);
      if (rvalid_out !== 1'h1) begin
        fail_count++;
        $display("BAD t=%0t no read data", $time);
      end
      chk(rdata_out, ref_mem[a]);
    end
  endtask : op

  // ceiling well above the several hundred cycles the run needs
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    logic [17:0] a;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'h1;
    // ready still low at the end of the wait, high one edge after it
    repeat (PU_TB) @(posedge clk_in);
    chk({15'h0, ready_out}, 16'h0000);
    @(posedge clk_in);
    chk({15'h0, ready_out}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      a = {2'(rnd()), rnd()};
      op(1'h1, a, rnd(), 2'h3, 1'h0);
      op(1'h0, a, 16'h0000, 2'h3, 1'h0);
    end
    a = {2'(rnd()), rnd()};
    // columns out of order: 0, 3, 2, 1
    for (int i = 0; i < 4; i++) op(1'h1, {a[17:2], 2'(i * 3)}, rnd(), 2'h3, 1'h1);
    for (int i = 0; i < 4; i++) op(1'h0, {a[17:2], 2'(i * 3)}, 16'h0000, 2'h3, 1'h1);
    op(1'h1, {a[17:2], 2'h0}, rnd(), 2'h2, 1'h1);
    op(1'h1, {a[17:2], 2'h0}, rnd(), 2'h1, 1'h1);
    op(1'h0, {a[17:2], 2'h0}, 16'h0000, 2'h3, 1'h1);
    op(1'h1, ~a, rnd(), 2'h3, 1'h1);
    op(1'h0, {a[17:2], 2'h1}, 16'h0000, 2'h3, 1'h0);
    repeat (2) @(posedge clk_in);
    chk({15'h0, cs_n}, 16'h0001);
    end_of_test();
  end
endmodule : tb_top
